// [hdl/ladder_pkg.sv]
// shared types and constants of the ladder boolean stack evaluator
package ladder_pkg;
   // ----------------------------------------------------------------
   // sizes and image layout
   // ----------------------------------------------------------------
   localparam int          STACK_LEVELS = 8;          // boolean stack depth
   localparam logic [3:0]  DEPTH_FULL   = 4'h8;       // depth at which a push overflows
   localparam logic [3:0]  DEPTH_PAIR   = 4'h2;       // least depth for a merge
   localparam logic [5:0]  OUT_BASE     = 6'h10;      // first output image bit
   localparam logic [15:0] PINS_RESET   = 16'h0000;   // physical outputs after reset
   // ----------------------------------------------------------------
   // timing of one immediate i/o access
   // ----------------------------------------------------------------
   localparam int          IO_ACCESS_NS  = 20;        // physical point access time
   localparam int          CLK_PERIOD_NS = 4;         // 250 mhz core clock
   localparam int          IO_CYCLES_INT = (IO_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0]  IO_WAIT_LOAD  = 3'(IO_CYCLES_INT - 1);
   // ----------------------------------------------------------------
   // instruction set
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_NOP        = 5'h00, OP_LOAD       = 5'h01, OP_LOAD_INV   = 5'h02,
      OP_AND        = 5'h03, OP_AND_INV    = 5'h04, OP_OR         = 5'h05,
      OP_OR_INV     = 5'h06, OP_PAR_MERGE  = 5'h07, OP_SER_MERGE  = 5'h08,
      OP_OUT        = 5'h09, OP_LOAD_IMM   = 5'h0a, OP_LOAD_INV_IMM = 5'h0b,
      OP_AND_IMM    = 5'h0c, OP_OR_IMM     = 5'h0d, OP_OUT_IMM    = 5'h0e,
      OP_CMP_LOAD   = 5'h0f, OP_CMP_AND    = 5'h10, OP_CMP_OR     = 5'h11,
      OP_END        = 5'h12
   } op_type;
   typedef enum logic [1:0] {
      CMP_EQ = 2'h0, CMP_NE = 2'h1, CMP_GE = 2'h2, CMP_LT = 2'h3
   } cmp_type;
   typedef enum logic [1:0] {
      PH_IDLE = 2'h0, PH_INPUT = 2'h1, PH_EXEC = 2'h2, PH_OUTPUT = 2'h3
   } phase_type;
   typedef enum logic [1:0] {
      ST_RUN  = 2'b01, ST_WAIT = 2'b10
   } fsm_type;
   // one instruction from the sequencer
   typedef struct packed {
      logic        valid;   // instruction offered this cycle
      logic        isr;     // belongs to a routine past the end mark
      op_type      op;      // operation
      cmp_type     cond;    // comparison kind
      logic [5:0]  addr;    // image bit or physical point
      logic [15:0] val_a;   // first 4-digit bcd value
      logic [15:0] val_b;   // second 4-digit bcd value
   } instr_type;
   // error flags reported to the sequencer
   typedef struct packed {
      logic overflow;       // push beyond eight levels
      logic underflow;      // merge with fewer than two levels
   } err_type;
endpackage

// [hdl/ladder_boolean_stack_evaluator.sv]
// boolean stack evaluator for relay-ladder instruction streams
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - instructions after end ignored except routines
// - load pushes image bit unchanged
// - inverted load pushes complemented image bit
// - series join ands contact into top
// - parallel join ors contact into top
// - and after coil continues same rung
// - parallel merge ors two branch results
// - series merge ands two branch results
// - boolean stack holds exactly eight levels
// - load pushes, older levels move down
// - merges fold two adjacent levels into one
// - push beyond eight levels raises error
// - compare two 4-digit values, four relations
// - immediate forms access physical points directly
// - ordinary i/o only in update phases
// - immediate access stalls execution until done
// - immediate read leaves input image untouched
// - later ordinary reads use image, immediates re-read
// - immediate output writes pin and image
// - coil copies top into image bit
module ladder_boolean_stack_evaluator (
   input  wire logic                 i_clk,
   input  wire logic                 i_rst_b,
   input  wire ladder_pkg::instr_type i_instr,
   input  wire ladder_pkg::phase_type i_phase,
   input  wire logic [15:0]          i_pins,
   output logic                      o_ready,
   output logic                      o_top,
   output logic [3:0]                o_depth,
   output logic                      o_at_end,
   output ladder_pkg::err_type       o_err,
   output logic [15:0]               o_pins
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      ladder_pkg::fsm_type   fsm;     // running or waiting on i/o
      logic [2:0]            cnt;     // i/o wait countdown
      ladder_pkg::instr_type pend;    // immediate instruction in flight
      logic [7:0]            stk;     // bit 0 is the top level
      logic [3:0]            depth;   // levels in use, 0..8
      logic                  coil;    // a coil ended the last rung
      logic                  at_end;  // end mark passed this scan
      ladder_pkg::err_type   err;     // sticky errors
      logic                  ready;   // instruction may be offered
      logic [63:0]           img;     // inputs, outputs, relays
      logic [15:0]           pins_out;// physical outputs
      logic [15:0]           sync1;   // first pin stage
      logic [15:0]           sync2;   // second pin stage
   } state_type;

   state_type q;                      // registered state
   state_type d;                      // next state
   logic      rst_meta_b;             // reset release, first stage
   logic      rst_n;                  // reset release, second stage
   logic      take;                   // instruction taken this cycle
   logic      contact_img;            // image bit at offered address
   logic      cmp_hit;                // comparison outcome
   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   // asserted at once, released after two clean edges
   // every state flop uses this copy, so none leaves reset a cycle early
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_meta_b <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_b <= 1'b1;
         rst_n      <= rst_meta_b;
      end
   end
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // taken only while running, in the execute phase, before end mark or in a routine
   // an offer outside these conditions is dropped with no answer
   assign take = (q.fsm == ladder_pkg::ST_RUN) && i_instr.valid && q.ready &&
                 (i_phase == ladder_pkg::PH_EXEC) && (!q.at_end || i_instr.isr);
   assign contact_img = q.img[i_instr.addr];

   // immediate forms go to the physical point
   function automatic logic is_imm(input ladder_pkg::op_type op);
      is_imm = (op == ladder_pkg::OP_LOAD_IMM) || (op == ladder_pkg::OP_LOAD_INV_IMM) ||
               (op == ladder_pkg::OP_AND_IMM) || (op == ladder_pkg::OP_OR_IMM) ||
               (op == ladder_pkg::OP_OUT_IMM);
   endfunction

   // bcd digits order like binary, so a plain compare is exact
   always_comb begin
      case (i_instr.cond)
         ladder_pkg::CMP_EQ: cmp_hit = (i_instr.val_a == i_instr.val_b);
         ladder_pkg::CMP_NE: cmp_hit = (i_instr.val_a != i_instr.val_b);
         ladder_pkg::CMP_GE: cmp_hit = (i_instr.val_a >= i_instr.val_b);
         default:            cmp_hit = (i_instr.val_a <  i_instr.val_b);
      endcase
   end
   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      ladder_pkg::instr_type cur;     // instruction executing now
      logic                  fire;    // execute cur this cycle
      logic                  val;     // contact value of cur
      logic                  push;    // cur starts a rung or branch
      d     = q;
      cur   = i_instr;
      fire  = 1'b0;
      val   = 1'b0;
      push  = 1'b0;
      // pins only reach logic after the second stage
      d.sync1 = i_pins;
      d.sync2 = q.sync1;
      // ordinary i/o moves only in its own scan phases
      if (i_phase == ladder_pkg::PH_INPUT) begin
         d.img[15:0] = q.sync2;
         d.at_end    = 1'b0;                          // new scan begins
      end
      if (i_phase == ladder_pkg::PH_OUTPUT) begin
         d.pins_out = q.img[31:16];
      end
      case (q.fsm)
         ladder_pkg::ST_RUN: begin
            if (take && is_imm(i_instr.op)) begin
               // hold execution while the point is accessed
               d.pend  = i_instr;
               d.cnt   = ladder_pkg::IO_WAIT_LOAD;
               d.fsm   = ladder_pkg::ST_WAIT;
               d.ready = 1'b0;
            end else begin
               fire = take;
            end
         end
         ladder_pkg::ST_WAIT: begin
            if (q.cnt == 3'h0) begin
               cur     = q.pend;
               fire    = 1'b1;
               d.fsm   = ladder_pkg::ST_RUN;
               d.ready = 1'b1;
            end else begin
               d.cnt = q.cnt - 3'h1;
            end
         end
         default: begin
            d.fsm   = ladder_pkg::ST_RUN;
            d.ready = 1'b1;
         end
      endcase
      // contact value source; an immediate read never writes the image
      if (is_imm(cur.op)) begin
         val = q.sync2[cur.addr[3:0]];
      end else if (cur.op == ladder_pkg::OP_CMP_LOAD || cur.op == ladder_pkg::OP_CMP_AND ||
                   cur.op == ladder_pkg::OP_CMP_OR) begin
         val = cmp_hit;
      end else begin
         val = q.img[cur.addr];
      end
      if (fire) begin
         case (cur.op)
            ladder_pkg::OP_LOAD, ladder_pkg::OP_LOAD_IMM, ladder_pkg::OP_CMP_LOAD: begin
               push = 1'b1;
            end
            ladder_pkg::OP_LOAD_INV, ladder_pkg::OP_LOAD_INV_IMM: begin
               val  = ~val;
               push = 1'b1;
            end
            ladder_pkg::OP_AND, ladder_pkg::OP_AND_IMM, ladder_pkg::OP_CMP_AND: begin
               d.stk[0] = q.stk[0] & val;
            end
            ladder_pkg::OP_AND_INV: begin
               d.stk[0] = q.stk[0] & ~val;
            end
            ladder_pkg::OP_OR, ladder_pkg::OP_OR_IMM, ladder_pkg::OP_CMP_OR: begin
               d.stk[0] = q.stk[0] | val;
            end
            ladder_pkg::OP_OR_INV: begin
               d.stk[0] = q.stk[0] | ~val;
            end
            ladder_pkg::OP_PAR_MERGE, ladder_pkg::OP_SER_MERGE: begin
               if (q.depth < ladder_pkg::DEPTH_PAIR) begin
                  d.err.underflow = 1'b1;
               end else begin
                  // fold the two top levels, lower ones move up
                  d.stk   = {1'b0, q.stk[7:1]};
                  d.stk[0] = (cur.op == ladder_pkg::OP_PAR_MERGE) ?
                             (q.stk[0] | q.stk[1]) :
                             (q.stk[0] & q.stk[1]);
                  d.depth = q.depth - 4'h1;
               end
            end
            ladder_pkg::OP_OUT: begin
               d.img[cur.addr] = q.stk[0];
               d.coil          = 1'b1;
            end
            ladder_pkg::OP_OUT_IMM: begin
               // the pin and its image bit change together
               d.pins_out[cur.addr[3:0]]                 = q.stk[0];
               d.img[ladder_pkg::OUT_BASE + {2'b00, cur.addr[3:0]}] = q.stk[0];
               d.coil                                    = 1'b1;
            end
            ladder_pkg::OP_END: begin
               d.at_end = 1'b1;
               d.depth  = 4'h0;
               d.coil   = 1'b0;
            end
            default: begin
            end
         endcase
         // the coil mark outlives contacts and merges; a load or the end clears it
         if (push) begin
            d.coil = 1'b0;
            if (q.coil) begin
               // a load after a coil opens a fresh rung
               d.depth  = 4'h1;
               d.stk[0] = val;
            end else begin
               // eight levels only; the bottom one is lost on overflow
               d.stk = {q.stk[6:0], val};
               if (q.depth == ladder_pkg::DEPTH_FULL) begin
                  d.err.overflow = 1'b1;
               end else begin
                  d.depth = q.depth + 4'h1;
               end
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         // fields not named below start at zero
         q          <= '0;
         q.fsm      <= ladder_pkg::ST_RUN;
         q.ready    <= 1'b1;
         q.pins_out <= ladder_pkg::PINS_RESET;
      end else begin
         q <= d;
      end
   end

   // every output is a field of the state register
   assign o_ready  = q.ready;
   assign o_top    = q.stk[0];
   assign o_depth  = q.depth;
   assign o_at_end = q.at_end;
   assign o_err    = q.err;
   assign o_pins   = q.pins_out;
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_n);

   a_load_value: assert property (take && i_instr.op == ladder_pkg::OP_LOAD
      |=> q.stk[0] == $past(contact_img)) else $error("load value wrong");
   a_inv_value: assert property (take && i_instr.op == ladder_pkg::OP_LOAD_INV
      |=> q.stk[0] == !$past(contact_img)) else $error("inverted load wrong");
   a_push_depth: assert property (take && i_instr.op == ladder_pkg::OP_LOAD && !q.coil &&
      q.depth < ladder_pkg::DEPTH_FULL |=> q.depth == $past(q.depth) + 4'h1 &&
      q.stk[1] == $past(q.stk[0])) else $error("push did not shift stack");
   a_stack_overflow: assert property (take && i_instr.op == ladder_pkg::OP_LOAD &&
      !q.coil && q.depth == ladder_pkg::DEPTH_FULL |=> q.err.overflow && q.depth == 4'h8)
      else $error("overflow not flagged");
   a_merge_pop: assert property (take && i_instr.op == ladder_pkg::OP_PAR_MERGE &&
      q.depth >= ladder_pkg::DEPTH_PAIR |=> q.depth == $past(q.depth) - 4'h1 &&
      q.stk[0] == ($past(q.stk[0]) | $past(q.stk[1]))) else $error("parallel merge wrong");
   a_ser_merge: assert property (take && i_instr.op == ladder_pkg::OP_SER_MERGE &&
      q.depth >= ladder_pkg::DEPTH_PAIR |=> q.depth == $past(q.depth) - 4'h1 &&
      q.stk[0] == ($past(q.stk[0]) & $past(q.stk[1]))) else $error("series merge wrong");
   a_merge_under: assert property (take && i_instr.op == ladder_pkg::OP_SER_MERGE &&
      q.depth < ladder_pkg::DEPTH_PAIR |=> q.err.underflow && $stable(q.depth))
      else $error("underflow not flagged");
   a_imm_stall: assert property (take && is_imm(i_instr.op)
      |=> !q.ready [*5] ##1 q.ready) else $error("immediate stall length wrong");
   a_imm_image: assert property (q.fsm == ladder_pkg::ST_WAIT &&
      q.pend.op == ladder_pkg::OP_LOAD_IMM && i_phase != ladder_pkg::PH_INPUT
      |=> $stable(q.img)) else $error("immediate read touched image");
   a_end_block: assert property (q.at_end && i_instr.valid && !i_instr.isr &&
      q.fsm == ladder_pkg::ST_RUN && i_phase == ladder_pkg::PH_EXEC
      |=> $stable(q.stk) && $stable(q.depth)) else $error("ran past end mark");
   a_coil_image: assert property (take && i_instr.op == ladder_pkg::OP_OUT
      |=> q.img[$past(i_instr.addr)] == $past(q.stk[0])) else $error("coil not copied");
   a_out_phase: assert property (q.fsm == ladder_pkg::ST_RUN &&
      i_phase != ladder_pkg::PH_OUTPUT |=> $stable(o_pins)) else $error("pins moved early");
   a_cmp_equal: assert property (take && i_instr.op == ladder_pkg::OP_CMP_LOAD &&
      i_instr.cond == ladder_pkg::CMP_EQ |=> q.stk[0] == $past(cmp_hit))
      else $error("compare result wrong");

   // covers for the main scenarios
   c_par_merge: cover property (take && i_instr.op == ladder_pkg::OP_PAR_MERGE);
   c_imm_out: cover property (q.fsm == ladder_pkg::ST_WAIT && q.pend.op == ladder_pkg::OP_OUT_IMM);
   c_overflow: cover property ($rose(q.err.overflow));
   c_end_mark: cover property ($rose(q.at_end));
endmodule
`default_nettype wire

// [testbench/field_io.sv]
// field i/o partner: drives the physical input points and watches the outputs
`timescale 1ns/1ps
`default_nettype none
module field_io (
   input  wire logic        i_clk,
   input  wire logic [15:0] i_lamps,
   output logic [15:0]      o_points,
   output logic [15:0]      o_lamps_seen
);
   // ------------------------------------------------------------
   // field side
   // ------------------------------------------------------------
   initial o_points = 16'h0000;   // all switches open at power up
   // loads follow the outputs one edge late, as a real output stage does
   always @(posedge i_clk) begin
      o_lamps_seen <= i_lamps;
   end
   // switches move only off the sampling edge, so no sync race is hidden
   task automatic set_points(input logic [15:0] v);
      @(negedge i_clk);
      o_points = v;
   endtask
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// self-checking testbench of the ladder boolean stack evaluator
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // ------------------------------------------------------------
   // hookup and reference model state
   // ------------------------------------------------------------
   logic                  clk = 1'b0;          // 250 mhz core clock
   logic                  rst_b = 1'b0;        // active low reset
   ladder_pkg::instr_type instr = '0;          // offered instruction
   ladder_pkg::phase_type phase = ladder_pkg::PH_IDLE; // scan phase
   logic [15:0]           pins_in;             // field inputs
   logic                  ready;               // offers accepted
   logic                  top;                 // rung result
   logic [3:0]            depth;               // levels in use
   logic                  at_end;              // end mark seen
   ladder_pkg::err_type   err;                 // sticky errors
   logic [15:0]           pins_out;            // physical outputs
   int                    err_count = 0;       // mismatches
   int                    checks_done = 0;     // comparisons
   logic [31:0]           rng = 32'h110a_5584; // xorshift state
   logic [63:0]           m_img;               // model image
   logic [7:0]            m_stk;               // model stack, bit 0 on top
   int                    m_depth;             // model depth
   logic [1:0]            m_err;               // model overflow, underflow
   logic                  m_end;               // model end mark
   logic                  m_coil;              // a coil ended the last rung
   logic [15:0]           m_pout;              // model outputs
   logic [15:0]           m_fld;               // field switch state
   logic [15:0]           lamps;               // outputs as the field saw them
   // directed rung: op code over image address
   localparam logic [10:0] PROG [16] = '{
      {5'h01, 6'h00}, {5'h03, 6'h01}, {5'h09, 6'h20}, {5'h04, 6'h02},
      {5'h09, 6'h21}, {5'h01, 6'h03}, {5'h02, 6'h04}, {5'h05, 6'h05},
      {5'h06, 6'h06}, {5'h08, 6'h00}, {5'h01, 6'h07}, {5'h03, 6'h08},
      {5'h07, 6'h00}, {5'h09, 6'h10}, {5'h01, 6'h0b}, {5'h0c, 6'h0a}};
   always #2 clk = ~clk;
   ladder_boolean_stack_evaluator uut (
      .i_clk(clk), .i_rst_b(rst_b), .i_instr(instr), .i_phase(phase),
      .i_pins(pins_in), .o_ready(ready), .o_top(top), .o_depth(depth),
      .o_at_end(at_end), .o_err(err), .o_pins(pins_out));
   field_io field (
      .i_clk(clk), .i_lamps(pins_out), .o_points(pins_in), .o_lamps_seen(lamps));
   // ------------------------------------------------------------
   // model and checking helpers
   // ------------------------------------------------------------
   function automatic logic is_imm(input ladder_pkg::op_type op);
      return op inside {ladder_pkg::OP_LOAD_IMM, ladder_pkg::OP_LOAD_INV_IMM,
         ladder_pkg::OP_AND_IMM, ladder_pkg::OP_OR_IMM, ladder_pkg::OP_OUT_IMM};
   endfunction
   task automatic push(input logic v);
      m_stk = {m_stk[6:0], v};
      if (m_coil) m_depth = 1;       // a load after a coil opens a new rung
      else if (m_depth == 8) m_err[1] = 1'b1;
      else m_depth++;
      m_coil = 1'b0;
   endtask
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic apply(input ladder_pkg::instr_type x);
      logic v;
      logic c;
      v = is_imm(x.op) ? m_fld[x.addr[3:0]] : m_img[x.addr];
      case (x.cond)
         ladder_pkg::CMP_EQ: c = x.val_a == x.val_b;
         ladder_pkg::CMP_NE: c = x.val_a != x.val_b;
         ladder_pkg::CMP_GE: c = x.val_a >= x.val_b;
         default:            c = x.val_a < x.val_b;
      endcase
      if (phase != ladder_pkg::PH_EXEC || (m_end && !x.isr)) return;
      case (x.op)
         ladder_pkg::OP_LOAD, ladder_pkg::OP_LOAD_IMM:         push(v);
         ladder_pkg::OP_LOAD_INV, ladder_pkg::OP_LOAD_INV_IMM: push(!v);
         ladder_pkg::OP_CMP_LOAD:                             push(c);
         ladder_pkg::OP_AND, ladder_pkg::OP_AND_IMM:           m_stk[0] &= v;
         ladder_pkg::OP_AND_INV:                              m_stk[0] &= !v;
         ladder_pkg::OP_CMP_AND:                              m_stk[0] &= c;
         ladder_pkg::OP_OR, ladder_pkg::OP_OR_IMM:             m_stk[0] |= v;
         ladder_pkg::OP_OR_INV:                               m_stk[0] |= !v;
         ladder_pkg::OP_CMP_OR:                               m_stk[0] |= c;
         ladder_pkg::OP_OUT:                                  m_img[x.addr] = m_stk[0];
         ladder_pkg::OP_PAR_MERGE, ladder_pkg::OP_SER_MERGE: begin
            if (m_depth < 2) m_err[0] = 1'b1;
            else begin
               m_stk = {1'b0, m_stk[7:2], x.op == ladder_pkg::OP_PAR_MERGE ?
                  m_stk[0] | m_stk[1] : m_stk[0] & m_stk[1]};
               m_depth--;
            end
         end
         ladder_pkg::OP_OUT_IMM: begin
            m_pout[x.addr[3:0]] = m_stk[0];
            m_img[ladder_pkg::OUT_BASE + 6'(x.addr[3:0])] = m_stk[0];
         end
         ladder_pkg::OP_END: begin
            m_depth = 0;
            m_end = 1'b1;
            m_coil = 1'b0;
         end
         default: ;
      endcase
      // the coil mark stays through contacts and merges until a load or the end
      if (x.op inside {ladder_pkg::OP_OUT, ladder_pkg::OP_OUT_IMM}) m_coil = 1'b1;
   endtask
   task automatic compare(input logic ok, input string what);
      checks_done++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("MISMATCH %0t %s", $time, what);
      end
   endtask
   task automatic check(input string what);
      compare(ready === 1'b1 && depth === 4'(m_depth) && err === m_err && at_end === m_end
         && pins_out === m_pout && (m_depth == 0 || top === m_stk[0]), what);
   endtask
   task automatic mreset();
      m_img = '0;
      m_stk = '0;
      m_depth = 0;
      m_err = '0;
      m_end = 1'b0;
      m_coil = 1'b0;
      m_pout = ladder_pkg::PINS_RESET;
   endtask
   // one offer; an immediate drops its offer and waits out the stall
   task automatic issue(input ladder_pkg::op_type op, input logic [5:0] addr,
         input ladder_pkg::cmp_type cond, input logic [15:0] a, input logic [15:0] b,
         input logic isr);
      int lows;
      ladder_pkg::instr_type x;
      x = '{1'b1, isr, op, cond, addr, a, b};
      lows = 0;
      instr = x;
      @(negedge clk);
      if (is_imm(op) && phase == ladder_pkg::PH_EXEC && (!m_end || isr)) begin
         instr.valid = 1'b0;
         while (ready !== 1'b1 && lows < 20) begin
            lows++;
            @(negedge clk);
         end
         compare(lows == ladder_pkg::IO_CYCLES_INT, "immediate stall length");
      end
      apply(x);
      check("state after instruction");
   endtask
   task automatic run(input ladder_pkg::op_type op, input logic [5:0] addr);
      issue(op, addr, ladder_pkg::CMP_EQ, 16'h0000, 16'h0000, 1'b0);
   endtask
   task automatic step(input ladder_pkg::phase_type p, input int n);
      instr.valid = 1'b0;
      phase = p;
      repeat (n) @(negedge clk);
      if (p == ladder_pkg::PH_INPUT) m_img[15:0] = m_fld;
      if (p == ladder_pkg::PH_INPUT) m_end = 1'b0;
      if (p == ladder_pkg::PH_OUTPUT) m_pout = m_img[31:16];
      check("state after phase");
      if (p == ladder_pkg::PH_OUTPUT) compare(lamps === m_pout, "field outputs");
   endtask
   // switches change with no offer pending; waits out the input sync
   task automatic pins(input logic [15:0] v);
      instr.valid = 1'b0;
      field.set_points(v);
      m_fld = v;
      repeat (3) @(negedge clk);
   endtask
   task automatic close_out();
      if (err_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ------------------------------------------------------------
   // stimulus
   // ------------------------------------------------------------
   initial begin
      #100us;
      err_count++;
      close_out();
   end
   initial begin
      ladder_pkg::op_type op;
      mreset();
      m_fld = 16'h0000;
      repeat (5) @(negedge clk);
      check("reset values");
      rst_b = 1'b1;
      pins(16'ha5c3);
      step(ladder_pkg::PH_INPUT, 3);
      step(ladder_pkg::PH_EXEC, 1);
      foreach (PROG[i]) run(ladder_pkg::op_type'(PROG[i][10:6]), PROG[i][5:0]);
      pins(16'h5a3c);
      run(ladder_pkg::OP_LOAD, 6'h03);
      run(ladder_pkg::OP_LOAD_IMM, 6'h03);
      run(ladder_pkg::OP_AND, 6'h03);
      run(ladder_pkg::OP_OUT_IMM, 6'h05);
      run(ladder_pkg::OP_OR_IMM, 6'h04);
      for (int c = 0; c < 4; c++) begin
         issue(ladder_pkg::OP_CMP_LOAD, 6'h00, ladder_pkg::cmp_type'(c), 16'h1234, 16'h1234, 1'b0);
         issue(ladder_pkg::OP_CMP_OR, 6'h00, ladder_pkg::cmp_type'(c), 16'h1234, 16'h9999, 1'b0);
         issue(ladder_pkg::OP_CMP_AND, 6'h00, ladder_pkg::cmp_type'(c), 16'h9999, 16'h1234, 1'b0);
      end
      run(ladder_pkg::OP_END, 6'h00);
      run(ladder_pkg::OP_LOAD, 6'h00);
      issue(ladder_pkg::OP_LOAD, 6'h01, ladder_pkg::CMP_EQ, 16'h0000, 16'h0000, 1'b1);
      step(ladder_pkg::PH_OUTPUT, 2);
      run(ladder_pkg::OP_LOAD, 6'h00);
      step(ladder_pkg::PH_INPUT, 3);
      step(ladder_pkg::PH_EXEC, 1);
      run(ladder_pkg::OP_OUT, 6'h30);
      run(ladder_pkg::OP_LOAD, 6'h00);
      run(ladder_pkg::OP_PAR_MERGE, 6'h00);
      repeat (8) run(ladder_pkg::OP_LOAD_INV, 6'h00);
      instr.valid = 1'b0;
      @(negedge clk);
      rst_b = 1'b0;
      mreset();
      repeat (2) @(negedge clk);
      check("reset in mid run");
      rst_b = 1'b1;
      for (int i = 0; i < 400; i++) begin
         if (i % 50 == 0) begin
            step(ladder_pkg::PH_OUTPUT, 2);
            pins(rng[15:0]);
            step(ladder_pkg::PH_INPUT, 3);
            step(ladder_pkg::PH_EXEC, 1);
         end
         rng = xorshift(rng);
         op = ladder_pkg::op_type'(5'(rng % 17 + 1));
         if (m_depth == 0 || (m_coil && op inside {ladder_pkg::OP_LOAD_INV,
               ladder_pkg::OP_LOAD_IMM, ladder_pkg::OP_LOAD_INV_IMM, ladder_pkg::OP_CMP_LOAD}))
            op = ladder_pkg::OP_LOAD;
         issue(op, rng[10:5], ladder_pkg::cmp_type'(rng[12:11]), rng[31:16],
            rng[4] ? rng[31:16] : rng[27:12], 1'b0);
      end
      close_out();
   end
endmodule
`default_nettype wire
